// ==== core/usbrh_top.sv ====
// Root hub port status registers with AXI4-Lite slave and interrupt logic.
// Operation
// - Reserved port bits read zero, ignore writes.
// - Bit 20 sets when port reset completes.
// - Bit 19 sets on overcurrent change; W1C.
// - Bit 18 sets when selective resume completes.
// - Bit 17 sets when hardware clears enable.
// - Bit 16 sets on connect change; W1C.
// - Non-removable port resets connect change to one.
// - Bit 9 reads low speed device attached.
// - Writing one to bit 9 powers off.
// - Bit 8 reads power; write one powers on.
// - Without power switching bit 8 reads one.
// - Two port registers; bus reset clears their change flags and power.
// - Bit 0 reads current connect status.
`timescale 1ns/1ns
`default_nettype none
module usbrh_top #(
  parameter int unsigned NUM_PORTS = 2
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [NUM_PORTS-1:0] connect_in,
  input wire logic [NUM_PORTS-1:0] low_speed_in,
  input wire logic [NUM_PORTS-1:0] overcurrent_in,
  input wire logic [NUM_PORTS-1:0] reset_done_in,
  input wire logic [NUM_PORTS-1:0] resume_done_in,
  input wire logic [NUM_PORTS-1:0] enable_lost_in,
  output logic [NUM_PORTS-1:0] power_on_out,
  output logic irq_out
);
  import usbrh_pkg::*;

  localparam int unsigned INT_W = NUM_PORTS * USBRH_NUM_EVENTS;

  // Address decode shared by the write and read paths.
  function automatic usbrh_sel_t decode(input logic [31:0] addr);
    usbrh_sel_t sel;
    sel = USBRH_SEL_NONE;
    unique case (addr)
      USBRH_PORT1_ADDR: sel = USBRH_SEL_PORT1;
      USBRH_PORT2_ADDR: sel = USBRH_SEL_PORT2;
      USBRH_CTRL_ADDR: sel = USBRH_SEL_CTRL;
      USBRH_INT_STATUS_ADDR: sel = USBRH_SEL_INT_STATUS;
      USBRH_INT_ENABLE_ADDR: sel = USBRH_SEL_INT_ENABLE;
      USBRH_INT_CLEAR_ADDR: sel = USBRH_SEL_INT_CLEAR;
      default: sel = USBRH_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Byte strobes widened to a bit mask.
  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Write channel state.
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, awready_q, awready_d, wready_q, wready_d;
  logic [1:0] bresp_q, bresp_d;
  logic do_write;
  usbrh_sel_t wsel;
  logic [31:0] wmasked;
  logic [31:0] wstrb_mask;

  // Read channel state.
  logic rvalid_q, rvalid_d, arready_q, arready_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // Software-visible registers.
  logic [31:0] ctrl_q, ctrl_d;
  logic [INT_W-1:0] int_status_q, int_status_d, int_enable_q, int_enable_d, int_clr;
  logic irq_q, irq_d;
  logic [NUM_PORTS-1:0] power_q, power_d;

  // Port side.
  logic [31:0] port_status [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_wr, port_power;
  logic [INT_W-1:0] port_events;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wsel = decode(awaddr_q);
  // The strobe mask is held in a net because a function result cannot be sliced directly.
  assign wstrb_mask = strobe_mask(wstrb_q);
  assign wmasked = wdata_q & wstrb_mask;

  // Address and data are caught independently; the write happens once both are held.
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid_in && awready_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata_in;
      wstrb_d = s_axi_wstrb_in;
    end
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wsel == USBRH_SEL_NONE) ? USBRH_RESP_SLVERR : USBRH_RESP_OKAY;
    end else if (bvalid_q && s_axi_bready_in) begin
      bvalid_d = 1'b0;
    end
    // Ready is registered, so it is computed from the next state.
    awready_d = !aw_full_d && !bvalid_d;
    wready_d = !w_full_d && !bvalid_d;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= USBRH_RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
    end
  end

  // Write strobes to the port instances carry strobe-masked data; reserved bits reach them but are not used.
  always_comb begin
    port_wr = '0;
    if (do_write && wsel == USBRH_SEL_PORT1) begin
      port_wr[0] = 1'b1;
    end
    if (do_write && wsel == USBRH_SEL_PORT2 && NUM_PORTS > 1) begin
      port_wr[NUM_PORTS-1] = 1'b1;
    end
  end

  // Control, interrupt enable and sticky interrupt status.
  always_comb begin
    ctrl_d = ctrl_q;
    int_enable_d = int_enable_q;
    int_clr = '0;
    if (do_write && wsel == USBRH_SEL_CTRL) begin
      ctrl_d = (ctrl_q & ~strobe_mask(wstrb_q)) | wmasked;
      ctrl_d[31:USBRH_CTRL_NONREM_LSB + NUM_PORTS] = '0;
    end
    if (do_write && wsel == USBRH_SEL_INT_ENABLE) begin
      int_enable_d = (int_enable_q & ~wstrb_mask[INT_W-1:0]) | wmasked[INT_W-1:0];
    end
    if (do_write && wsel == USBRH_SEL_INT_CLEAR) begin
      int_clr = wmasked[INT_W-1:0];
    end
    // An event landing with its clear keeps the bit set.
    int_status_d = port_events | (int_status_q & ~int_clr);
    irq_d = |(int_status_d & int_enable_d);
    power_d = port_power;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= USBRH_CTRL_RESET;
      int_enable_q <= '0;
      int_status_q <= '0;
      irq_q <= 1'b0;
      power_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      int_enable_q <= int_enable_d;
      int_status_q <= int_status_d;
      irq_q <= irq_d;
      power_q <= power_d;
    end
  end

  // Read path; data is registered, so the answer comes one cycle after the address.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid_in && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = USBRH_RESP_OKAY;
      unique case (decode(s_axi_araddr_in))
        USBRH_SEL_PORT1: rdata_d = port_status[0] & ~USBRH_PORT_RSVD_MASK;
        USBRH_SEL_PORT2: rdata_d = port_status[NUM_PORTS-1] & ~USBRH_PORT_RSVD_MASK;
        USBRH_SEL_CTRL: rdata_d = ctrl_q;
        USBRH_SEL_INT_STATUS: rdata_d = 32'(int_status_q);
        USBRH_SEL_INT_ENABLE: rdata_d = 32'(int_enable_q);
        USBRH_SEL_INT_CLEAR: rdata_d = 32'h0000_0000;
        USBRH_SEL_NONE: begin
          rdata_d = 32'h0000_0000;
          rresp_d = USBRH_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= USBRH_RESP_OKAY;
      arready_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arready_q <= arready_d;
    end
  end

  // One port instance per root hub port.
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    usbrh_port u_port (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .bus_reset_in(ctrl_q[USBRH_CTRL_BUS_RESET_BIT]),
      .always_powered_in(ctrl_q[USBRH_CTRL_ALWAYS_POWERED_BIT]),
      .non_removable_in(ctrl_q[USBRH_CTRL_NONREM_LSB + p]),
      .connect_in(connect_in[p]),
      .low_speed_in(low_speed_in[p]),
      .overcurrent_in(overcurrent_in[p]),
      .reset_done_in(reset_done_in[p]),
      .resume_done_in(resume_done_in[p]),
      .enable_lost_in(enable_lost_in[p]),
      .wr_in(port_wr[p]),
      .wdata_in(wmasked),
      .status_out(port_status[p]),
      .power_out(port_power[p]),
      .event_out(port_events[p*USBRH_NUM_EVENTS +: USBRH_NUM_EVENTS])
    );
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign power_on_out = power_q;
  assign irq_out = irq_q;

  sequence s_port1_read;
    s_axi_arvalid_in && arready_q && decode(s_axi_araddr_in) == USBRH_SEL_PORT1;
  endsequence

  property p_rsvd_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_port1_read |=> (rvalid_q && (rdata_q & USBRH_PORT_RSVD_MASK) == 32'h0000_0000);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved port bits not zero");

  property p_resume_flag;
    @(posedge clk_in) disable iff (sys_rst_in)
      (resume_done_in[0] && !ctrl_q[USBRH_CTRL_BUS_RESET_BIT])
        |=> (port_status[0][USBRH_CHG_LSB + USBRH_EV_RESUME_DONE] && int_status_q[USBRH_EV_RESUME_DONE]);
  endproperty
  a_resume_flag: assert property (p_resume_flag) else $error("resume done flag not set");

  property p_enable_lost;
    @(posedge clk_in) disable iff (sys_rst_in)
      (enable_lost_in[0] && !ctrl_q[USBRH_CTRL_BUS_RESET_BIT])
        |=> port_status[0][USBRH_CHG_LSB + USBRH_EV_ENABLE_LOST] ##1 irq_q == |(int_status_q & int_enable_q);
  endproperty
  a_enable_lost: assert property (p_enable_lost) else $error("enable lost flag not set");

  property p_low_speed;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_port1_read ##1 rvalid_q |-> rdata_q[USBRH_LOW_SPEED_BIT] == $past(low_speed_in[0], 2);
  endproperty
  a_low_speed: assert property (p_low_speed) else $error("low speed bit wrong");

  property p_connect_bit;
    @(posedge clk_in) disable iff (sys_rst_in)
      s_port1_read |=> rdata_q[USBRH_CONNECT_BIT] == $past(connect_in[0] | ctrl_q[USBRH_CTRL_NONREM_LSB]);
  endproperty
  a_connect_bit: assert property (p_connect_bit) else $error("connect bit wrong");

  property p_w1c_resume;
    @(posedge clk_in) disable iff (sys_rst_in)
      (port_wr[0] && wmasked[USBRH_CHG_LSB + USBRH_EV_RESUME_DONE] && !resume_done_in[0])
        |=> !port_status[0][USBRH_CHG_LSB + USBRH_EV_RESUME_DONE];
  endproperty
  a_w1c_resume: assert property (p_w1c_resume) else $error("resume flag not cleared by write one");

  // Second port: its own clear, its bus reset, and the power pin of the first port.
  property p_w1c_enable_lost;
    @(posedge clk_in) disable iff (sys_rst_in)
      (port_wr[NUM_PORTS-1] && wmasked[USBRH_CHG_LSB + USBRH_EV_ENABLE_LOST] && !enable_lost_in[NUM_PORTS-1])
        |=> !port_status[NUM_PORTS-1][USBRH_CHG_LSB + USBRH_EV_ENABLE_LOST];
  endproperty
  a_w1c_enable_lost: assert property (p_w1c_enable_lost) else $error("enable lost flag not cleared");

  property p_port2_bus_reset;
    @(posedge clk_in) disable iff (sys_rst_in)
      ctrl_q[USBRH_CTRL_BUS_RESET_BIT] |=> port_status[NUM_PORTS-1][USBRH_CHG_LSB + 1 +: 4] == 4'h0;
  endproperty
  a_port2_bus_reset: assert property (p_port2_bus_reset) else $error("second port flags survive bus reset");

  // The power pin lags the status bit by one register stage.
  property p_power_pin;
    @(posedge clk_in) disable iff (sys_rst_in)
      (port_wr[0] && wmasked[USBRH_POWER_BIT] && !wmasked[USBRH_POWER_CLEAR_BIT] && !ctrl_q[USBRH_CTRL_BUS_RESET_BIT])
        |-> ##2 power_on_out[0];
  endproperty
  a_power_pin: assert property (p_power_pin) else $error("power pin not raised after power on");
endmodule
`default_nettype wire

// ==== core/usbrh_pkg.sv ====
// Package with the register map, field positions and codes of the root hub port status block.
package usbrh_pkg;

  // Byte addresses of the port status registers.
  localparam logic [31:0] USBRH_PORT1_ADDR = 32'hFFF0_5054;
  localparam logic [31:0] USBRH_PORT2_ADDR = 32'hFFF0_5058;
  // Byte addresses of the control and interrupt registers.
  localparam logic [31:0] USBRH_CTRL_ADDR = 32'hFFF0_5070;
  localparam logic [31:0] USBRH_INT_STATUS_ADDR = 32'hFFF0_5074;
  localparam logic [31:0] USBRH_INT_ENABLE_ADDR = 32'hFFF0_5078;
  localparam logic [31:0] USBRH_INT_CLEAR_ADDR = 32'hFFF0_507C;

  // Reset values.
  localparam logic [31:0] USBRH_PORT_RESET = 32'h0000_0000;
  localparam logic [31:0] USBRH_CTRL_RESET = 32'h0000_0001;

  // Reserved bits of a port status word: 31..21, 15..10 and 7..5.
  localparam logic [31:0] USBRH_PORT_RSVD_MASK = 32'hFFE0_FCE0;

  // Port status field positions; the five change flags sit at 16..20.
  localparam int unsigned USBRH_CHG_LSB = 16;
  localparam int unsigned USBRH_NUM_EVENTS = 5;
  localparam int unsigned USBRH_EV_CONNECT = 0;
  localparam int unsigned USBRH_EV_ENABLE_LOST = 1;
  localparam int unsigned USBRH_EV_RESUME_DONE = 2;
  localparam int unsigned USBRH_EV_OVERCURRENT = 3;
  localparam int unsigned USBRH_EV_RESET_DONE = 4;
  localparam int unsigned USBRH_LOW_SPEED_BIT = 9;
  localparam int unsigned USBRH_POWER_CLEAR_BIT = 9;
  localparam int unsigned USBRH_POWER_BIT = 8;
  localparam int unsigned USBRH_CONNECT_BIT = 0;

  // Control register fields.
  localparam int unsigned USBRH_CTRL_BUS_RESET_BIT = 0;
  localparam int unsigned USBRH_CTRL_ALWAYS_POWERED_BIT = 1;
  localparam int unsigned USBRH_CTRL_NONREM_LSB = 2;

  // AXI response codes.
  localparam logic [1:0] USBRH_RESP_OKAY = 2'h0;
  localparam logic [1:0] USBRH_RESP_SLVERR = 2'h2;

  // Register selected by a bus address.
  typedef enum {
    USBRH_SEL_PORT1,
    USBRH_SEL_PORT2,
    USBRH_SEL_CTRL,
    USBRH_SEL_INT_STATUS,
    USBRH_SEL_INT_ENABLE,
    USBRH_SEL_INT_CLEAR,
    USBRH_SEL_NONE
  } usbrh_sel_t;

endpackage

// ==== core/usbrh_port.sv ====
// Per-port status and control logic of one root hub port.
`timescale 1ns/1ns
`default_nettype none
module usbrh_port (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic bus_reset_in,
  input wire logic always_powered_in,
  input wire logic non_removable_in,
  input wire logic connect_in,
  input wire logic low_speed_in,
  input wire logic overcurrent_in,
  input wire logic reset_done_in,
  input wire logic resume_done_in,
  input wire logic enable_lost_in,
  input wire logic wr_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] status_out,
  output logic power_out,
  output logic [usbrh_pkg::USBRH_NUM_EVENTS-1:0] event_out
);
  import usbrh_pkg::*;

  logic [USBRH_NUM_EVENTS-1:0] chg_q, chg_d, set_ev, clr_ev;
  logic pps_q, pps_d, low_speed_attached_q, low_speed_attached_d;
  logic conn_prev_q, conn_prev_d, oc_prev_q, oc_prev_d;
  logic connected;

  // Next state of change flags, power and the edge trackers.
  always_comb begin
    set_ev = '0;
    set_ev[USBRH_EV_CONNECT] = connect_in ^ conn_prev_q;
    set_ev[USBRH_EV_ENABLE_LOST] = enable_lost_in;
    set_ev[USBRH_EV_RESUME_DONE] = resume_done_in;
    set_ev[USBRH_EV_OVERCURRENT] = overcurrent_in ^ oc_prev_q;
    set_ev[USBRH_EV_RESET_DONE] = reset_done_in;
    clr_ev = wr_in ? wdata_in[USBRH_CHG_LSB +: USBRH_NUM_EVENTS] : '0;
    conn_prev_d = connect_in;
    oc_prev_d = overcurrent_in;
    low_speed_attached_d = low_speed_in;
    if (bus_reset_in) begin
      // Bus reset clears the change flags and power; a fixed device reports a pending connect change.
      chg_d = '0;
      chg_d[USBRH_EV_CONNECT] = non_removable_in;
      pps_d = 1'b0;
      event_out = '0;
    end else begin
      // A new event beats a clear written in the same cycle, so nothing is lost.
      chg_d = set_ev | (chg_q & ~clr_ev);
      event_out = set_ev;
      if (wr_in && wdata_in[USBRH_POWER_CLEAR_BIT]) begin
        pps_d = 1'b0;
      end else if (wr_in && wdata_in[USBRH_POWER_BIT]) begin
        pps_d = 1'b1;
      end else begin
        pps_d = pps_q;
      end
    end
  end

  // Registers of the port.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      chg_q <= '0;
      pps_q <= 1'b0;
      low_speed_attached_q <= 1'b0;
      conn_prev_q <= 1'b0;
      oc_prev_q <= 1'b0;
    end else begin
      chg_q <= chg_d;
      pps_q <= pps_d;
      low_speed_attached_q <= low_speed_attached_d;
      conn_prev_q <= conn_prev_d;
      oc_prev_q <= oc_prev_d;
    end
  end

  // Read view; reserved and unimplemented bits stay zero.
  assign connected = connect_in | non_removable_in;
  always_comb begin
    status_out = USBRH_PORT_RESET;
    status_out[USBRH_CHG_LSB +: USBRH_NUM_EVENTS] = chg_q;
    status_out[USBRH_LOW_SPEED_BIT] = low_speed_attached_q;
    status_out[USBRH_POWER_BIT] = pps_q | always_powered_in;
    status_out[USBRH_CONNECT_BIT] = connected;
  end
  assign power_out = pps_q | always_powered_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_oc_change;
    (!bus_reset_in && overcurrent_in != oc_prev_q) |=> status_out[USBRH_CHG_LSB + USBRH_EV_OVERCURRENT];
  endproperty
  a_oc_change: assert property (p_oc_change) else $error("overcurrent change flag not set");

  property p_conn_clear;
    (!bus_reset_in && wr_in && wdata_in[USBRH_CHG_LSB] && connect_in == conn_prev_q) |=> !chg_q[USBRH_EV_CONNECT];
  endproperty
  a_conn_clear: assert property (p_conn_clear) else $error("connect change not cleared by write one");

  property p_reset_done;
    (!bus_reset_in && reset_done_in) |=> chg_q[USBRH_EV_RESET_DONE] ##1 (chg_q[USBRH_EV_RESET_DONE] || $past(wr_in));
  endproperty
  a_reset_done: assert property (p_reset_done) else $error("reset done flag lost");

  property p_power_off;
    (!bus_reset_in && wr_in && wdata_in[USBRH_POWER_CLEAR_BIT]) |=> (!pps_q && power_out == always_powered_in);
  endproperty
  a_power_off: assert property (p_power_off) else $error("power not switched off");

  property p_power_on;
    (!bus_reset_in && wr_in && wdata_in[USBRH_POWER_BIT] && !wdata_in[USBRH_POWER_CLEAR_BIT]) |=> status_out[USBRH_POWER_BIT];
  endproperty
  a_power_on: assert property (p_power_on) else $error("power not switched on");

  property p_always_powered;
    always_powered_in |-> (status_out[USBRH_POWER_BIT] && power_out);
  endproperty
  a_always_powered: assert property (p_always_powered) else $error("power bit low without switching");

  property p_bus_reset;
    bus_reset_in |=> ((status_out & 32'h001F_0100) == {15'h0, $past(non_removable_in), 16'h0} || always_powered_in);
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset left status set");
endmodule
`default_nettype wire

// ==== tb/usbrh_dev_model.sv ====
// Behavioural model of the devices attached to the two root hub ports.
`timescale 1ns/1ns
`default_nettype none
module usbrh_dev_model (
  input wire logic clk_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_port_in,
  input wire logic [2:0] cmd_kind_in,
  output logic [1:0] connect_out,
  output logic [1:0] low_speed_out,
  output logic [1:0] overcurrent_out,
  output logic [1:0] reset_done_out,
  output logic [1:0] resume_done_out,
  output logic [1:0] enable_lost_out
);
  // Both ports start empty, free of overcurrent and quiet.
  initial begin
    connect_out = 2'h0;
    low_speed_out = 2'h0;
    overcurrent_out = 2'h0;
    reset_done_out = 2'h0;
    resume_done_out = 2'h0;
    enable_lost_out = 2'h0;
  end

  // Kinds: 0 attach full speed, 1 attach low speed, 2 detach, 3 toggle overcurrent, 4 reset done, 5 resume done and 6 enable lost pulses.
  // A detached port sees both data lines pulled down, so it reports full speed rather than a stale value.
  always @(posedge clk_in) begin
    reset_done_out <= 2'h0;
    resume_done_out <= 2'h0;
    enable_lost_out <= 2'h0;
    if (cmd_valid_in) begin
      case (cmd_kind_in)
        3'h0, 3'h1: begin
          connect_out[cmd_port_in] <= 1'b1;
          low_speed_out[cmd_port_in] <= cmd_kind_in[0];
        end
        3'h2: begin
          connect_out[cmd_port_in] <= 1'b0;
          low_speed_out[cmd_port_in] <= 1'b0;
        end
        3'h3: overcurrent_out[cmd_port_in] <= ~overcurrent_out[cmd_port_in];
        3'h4: reset_done_out[cmd_port_in] <= 1'b1;
        3'h5: resume_done_out[cmd_port_in] <= 1'b1;
        3'h6: enable_lost_out[cmd_port_in] <= 1'b1;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/usbrh_top_test.sv ====
// Self-checking bench of the root hub port status block.
`timescale 1ns/1ns
`default_nettype none
module usbrh_top_test;
  import usbrh_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d, port_addr;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, cmd_valid = 1'b0, cmd_port = 1'b0;
  logic [1:0] bresp, rresp, conn, lows, ovc, rdone, sdone, elost, pwr;
  logic [2:0] cmd_kind = 3'h0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int miscompares = 0;
  int n_checks = 0;
  integer seed = 32'h1E17;
  int bits[4] = '{19, 20, 18, 17};

  // Free-running bench clock.
  initial forever #20 clk_in = ~clk_in;

  usbrh_top u_usbrh_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .connect_in(conn), .low_speed_in(lows), .overcurrent_in(ovc),
    .reset_done_in(rdone), .resume_done_in(sdone), .enable_lost_in(elost), .power_on_out(pwr),
    .irq_out(irq));

  usbrh_dev_model u_usbrh_dev_model (.clk_in(clk_in), .cmd_valid_in(cmd_valid), .cmd_port_in(cmd_port),
    .cmd_kind_in(cmd_kind), .connect_out(conn), .low_speed_out(lows), .overcurrent_out(ovc),
    .reset_done_out(rdone), .resume_done_out(sdone), .enable_lost_out(elost));

  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] want);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timed_out();
    miscompares++;
    $display("mismatch bus answer expected 1 seen 0");
    end_of_test();
  endtask

  // Write: address and data offered together, each dropped once taken; bready held until bvalid.
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] resp);
    int n;
    n = 0;
    exp_b.push_back(resp);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk_in);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
      if (n > 50) timed_out();
    end
    bready <= 1'b0;
  endtask

  // Read: the expected word and response are noted before the request goes out.
  task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] resp);
    int n;
    n = 0;
    exp_r.push_back({resp, v});
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk_in);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
      if (n > 50) timed_out();
    end
    rready <= 1'b0;
  endtask

  // Commands the device model, then lets the flag and the interrupt settle.
  task automatic ev(input logic p, input logic [2:0] k);
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_port <= p;
    cmd_kind <= k;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  // Each bus answer retires the oldest expectation of its channel.
  always @(posedge clk_in) begin
    if (rvalid && rready) chk("read", {rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, exp_b.pop_front()});
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(USBRH_PORT1_ADDR, 32'h0, USBRH_RESP_OKAY);
    rd(USBRH_PORT2_ADDR, 32'h0, USBRH_RESP_OKAY);
    wr(USBRH_CTRL_ADDR, 32'h0, USBRH_RESP_OKAY);
    wr(USBRH_INT_ENABLE_ADDR, 32'h3FF, USBRH_RESP_OKAY);
    $display("test reset done");
    ev(1'b0, 3'h1);
    chk("irq", {33'h0, irq}, 34'h1);
    rd(USBRH_PORT1_ADDR, 32'h0001_0201, USBRH_RESP_OKAY);
    wr(USBRH_PORT1_ADDR, 32'hFFFF_FFFF, USBRH_RESP_OKAY);
    rd(USBRH_PORT1_ADDR, 32'h0000_0201, USBRH_RESP_OKAY);
    wr(USBRH_PORT1_ADDR, 32'h0000_0100, USBRH_RESP_OKAY);
    rd(USBRH_PORT1_ADDR, 32'h0000_0301, USBRH_RESP_OKAY);
    chk("power", {32'h0, pwr}, 34'h1);
    wr(USBRH_PORT1_ADDR, 32'h0, USBRH_RESP_OKAY);
    rd(USBRH_PORT1_ADDR, 32'h0000_0301, USBRH_RESP_OKAY);
    wr(USBRH_PORT1_ADDR, 32'h0000_0200, USBRH_RESP_OKAY);
    rd(USBRH_PORT1_ADDR, 32'h0000_0201, USBRH_RESP_OKAY);
    wr(USBRH_INT_CLEAR_ADDR, 32'h3FF, USBRH_RESP_OKAY);
    repeat (2) @(posedge clk_in);
    chk("irq", {33'h0, irq}, 34'h0);
    $display("test connect and power done");
    // Overcurrent, reset done, resume done and enable lost on port 2 then port 1, each set then cleared.
    for (int i = 0; i < 8; i++) begin
      port_addr = i[2] ? USBRH_PORT1_ADDR : USBRH_PORT2_ADDR;
      d = i[2] ? 32'h0000_0201 : 32'h0000_0000;
      ev(!i[2], 3'(3 + i % 4));
      rd(port_addr, d | (32'h1 << bits[i % 4]), USBRH_RESP_OKAY);
      wr(port_addr, 32'h1 << bits[i % 4], USBRH_RESP_OKAY);
      rd(port_addr, d, USBRH_RESP_OKAY);
    end
    $display("test change flags done");
    wr(USBRH_INT_ENABLE_ADDR, 32'h0, USBRH_RESP_OKAY);
    wr(USBRH_INT_CLEAR_ADDR, 32'h3FF, USBRH_RESP_OKAY);
    ev(1'b0, 3'h2);
    chk("irq", {33'h0, irq}, 34'h0);
    rd(USBRH_PORT1_ADDR, 32'h0001_0000, USBRH_RESP_OKAY);
    // Random patterns confined to reserved bits must change nothing.
    for (int i = 0; i < 3; i++) begin
      d = $random(seed) & USBRH_PORT_RSVD_MASK;
      wr(USBRH_PORT2_ADDR, d, USBRH_RESP_OKAY);
      rd(USBRH_PORT2_ADDR, 32'h0, USBRH_RESP_OKAY);
    end
    wr(32'hFFF0_5060, 32'hFFFF_FFFF, USBRH_RESP_SLVERR);
    rd(32'hFFF0_5060, 32'h0, USBRH_RESP_SLVERR);
    $display("test reserved and unmapped done");
    wr(USBRH_CTRL_ADDR, 32'h2, USBRH_RESP_OKAY);
    rd(USBRH_PORT2_ADDR, 32'h0000_0100, USBRH_RESP_OKAY);
    chk("power", {32'h0, pwr}, 34'h3);
    ev(1'b1, 3'h4);
    wr(USBRH_CTRL_ADDR, 32'h5, USBRH_RESP_OKAY);
    rd(USBRH_PORT1_ADDR, 32'h0001_0001, USBRH_RESP_OKAY);
    rd(USBRH_PORT2_ADDR, 32'h0, USBRH_RESP_OKAY);
    $display("test bus reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
